// ---- design/tpg_generator.sv ----
// Function
// R1 - eight reference bars in fixed byte order
// R2 - last bar stretches to fill line
// R3 - bar count selectable one, two, four, eight
// R4 - line length and bar width programmable
// R5 - packets carry programmed datatype and channel
// R6 - active and total line counts programmable
// R7 - line period programmable in 10 ns
// R8 - front porch lines before frame end
// R9 - back porch lines after frame start
// R10 - runs on transmit clock, no crossing
// R11 - software keeps bars whole blocks
// R12 - fixed mode repeats programmed bytes
// R13 - fixed mode alternates true and inverted
// R14 - fixed block size one to sixteen
// R15 - sixteen byte-wide pattern value registers
// R16 - software sizes raw10/raw12 blocks correctly
// R17 - software computes bar size from blocks
// R18 - software sets line length from pixels
// R19 - host reaches registers through page window
// R20 - each line restarts, frames repeat identically
`timescale 1ns/1ps
`default_nettype none
`include "tpg_consts.svh"

module tpg_generator
  import tpg_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int PAT_BYTES = 16
) (
  // clock and reset (transmit clock)
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // csi-2 formatted stream to transmitter
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [1:0] tx_kind,
  output logic [7:0] tx_data,
  output logic tx_last,
  output logic [5:0] tx_dt,
  output logic [1:0] tx_vc,
  output logic [15:0] tx_word_count
);

  // elaboration check on parameters
  if (ADDR_W != 8 || PAT_BYTES != 16) begin : g_param_check
    $error("tpg_generator: ADDR_W must be 8 and PAT_BYTES 16");
  end

  tpg_s_t s_q;
  tpg_s_t s_d;
  logic [7:0] src_byte;
  logic [5:0] ar_idx;

  // byte lane merge for a partial write
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // index of a register word inside the window
  function automatic logic [5:0] word_idx(input logic [ADDR_W-1:0] a);
    return a[7:2];
  endfunction

  // last bar index for the programmed bar count
  function automatic logic [2:0] bars_max(input logic [1:0] code);
    return 3'((4'h1 << code) - 4'h1);
  endfunction

  // pattern byte for current position
  tpg_byte_source u_src (
    .fixed_mode(s_q.cfg_fixed),
    .bar_idx(s_q.bar_idx),
    .blk_idx(s_q.blk_idx),
    .pat(s_q.pat),
    .byte_out(src_byte)
  );

  assign ar_idx = word_idx(s_axi_araddr);

  // bus handshakes
  assign s_axi_awready = !s_q.aw_have && !s_q.bvalid;
  assign s_axi_wready = !s_q.w_have && !s_q.bvalid;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;

  // stream outputs, all from flops
  assign tx_valid = s_q.tx_valid; // R10
  assign tx_kind = s_q.tx_kind;
  assign tx_data = s_q.tx_data;
  assign tx_last = s_q.tx_last;
  assign tx_dt = s_q.dt; // R5
  assign tx_vc = s_q.vc; // R5
  assign tx_word_count = s_q.line_len;

  // next state of the whole block
  always_comb begin
    logic slot;
    logic [31:0] wv;
    logic [31:0] rv;
    logic [16:0] first_act;
    logic [16:0] end_act;
    logic [16:0] eof_line;
    logic [23:0] acc_nx;
    logic [15:0] nl;
    logic go_line;
    s_d = s_q;
    slot = !s_q.tx_valid || tx_ready;
    wv = 32'h0000_0000;
    rv = 32'h0000_0000;
    first_act = {9'h000, s_q.vbp};
    end_act = first_act + {1'b0, s_q.act};
    eof_line = end_act + {9'h000, s_q.vfp};
    acc_nx = s_q.acc + 24'(`TPG_STEP_UNITS);
    nl = 16'h0000;
    go_line = 1'b0;

    // write side: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_have = 1'b1;
      s_d.aw_idx = word_idx(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_have = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end

    // register write once both halves are held
    if (s_q.aw_have && s_q.w_have) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = `TPG_RESP_OKAY;
      if (s_q.aw_idx[5:4] == 2'(`TPG_OFF_PAT0 >> 6)) begin
        wv = merge({24'h0, s_q.pat[s_q.aw_idx[3:0]]}, s_q.wdata, s_q.wstrb);
        s_d.pat[s_q.aw_idx[3:0]] = wv[7:0]; // R15
      end else begin
        unique case ({s_q.aw_idx, 2'b00})
          `TPG_OFF_CTRL: begin
            wv = merge({31'h0, s_q.ctrl_en}, s_q.wdata, s_q.wstrb);
            s_d.ctrl_en = wv[`TPG_CTRL_EN_BIT];
          end
          `TPG_OFF_CFG: begin
            wv = merge({20'h0, s_q.cfg_blk, 3'h0, s_q.cfg_fixed, 2'h0,
                        s_q.cfg_bars}, s_q.wdata, s_q.wstrb);
            s_d.cfg_bars = wv[`TPG_CFG_BARS_LSB +: 2]; // R3
            s_d.cfg_fixed = wv[`TPG_CFG_FIXED_BIT];
            s_d.cfg_blk = wv[`TPG_CFG_BLK_LSB +: 4]; // R14
          end
          `TPG_OFF_CSI_ID: begin
            wv = merge({24'h0, s_q.vc, s_q.dt}, s_q.wdata, s_q.wstrb);
            s_d.dt = wv[`TPG_ID_DT_LSB +: 6]; // R5
            s_d.vc = wv[`TPG_ID_VC_LSB +: 2];
          end
          `TPG_OFF_LINE_LEN: begin
            wv = merge({16'h0, s_q.line_len}, s_q.wdata, s_q.wstrb);
            s_d.line_len = wv[15:0]; // R4
          end
          `TPG_OFF_BAR_W: begin
            wv = merge({16'h0, s_q.bar_w}, s_q.wdata, s_q.wstrb);
            s_d.bar_w = wv[15:0]; // R4
          end
          `TPG_OFF_ACT: begin
            wv = merge({16'h0, s_q.act}, s_q.wdata, s_q.wstrb);
            s_d.act = wv[15:0]; // R6
          end
          `TPG_OFF_TOT: begin
            wv = merge({16'h0, s_q.tot}, s_q.wdata, s_q.wstrb);
            s_d.tot = wv[15:0]; // R6
          end
          `TPG_OFF_PERIOD: begin
            wv = merge({16'h0, s_q.period}, s_q.wdata, s_q.wstrb);
            s_d.period = wv[15:0]; // R7
          end
          `TPG_OFF_VBP: begin
            wv = merge({24'h0, s_q.vbp}, s_q.wdata, s_q.wstrb);
            s_d.vbp = wv[7:0]; // R9
          end
          `TPG_OFF_VFP: begin
            wv = merge({24'h0, s_q.vfp}, s_q.wdata, s_q.wstrb);
            s_d.vfp = wv[7:0]; // R8
          end
          `TPG_OFF_STATUS: begin
          end
          default: begin
            s_d.bresp = `TPG_RESP_SLVERR;
          end
        endcase
      end
    end

    // read side: one cycle from address to data
    if (s_axi_rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = `TPG_RESP_OKAY;
      if (ar_idx[5:4] == 2'(`TPG_OFF_PAT0 >> 6)) begin
        rv = {24'h0, s_q.pat[ar_idx[3:0]]};
      end else begin
        unique case ({ar_idx, 2'b00})
          `TPG_OFF_CTRL: rv = {31'h0, s_q.ctrl_en};
          `TPG_OFF_CFG: rv = {20'h0, s_q.cfg_blk, 3'h0, s_q.cfg_fixed, 2'h0,
                              s_q.cfg_bars};
          `TPG_OFF_CSI_ID: rv = {24'h0, s_q.vc, s_q.dt};
          `TPG_OFF_LINE_LEN: rv = {16'h0, s_q.line_len};
          `TPG_OFF_BAR_W: rv = {16'h0, s_q.bar_w};
          `TPG_OFF_ACT: rv = {16'h0, s_q.act};
          `TPG_OFF_TOT: rv = {16'h0, s_q.tot};
          `TPG_OFF_PERIOD: rv = {16'h0, s_q.period};
          `TPG_OFF_VBP: rv = {24'h0, s_q.vbp};
          `TPG_OFF_VFP: rv = {24'h0, s_q.vfp};
          `TPG_OFF_STATUS: rv = {s_q.frames, s_q.line};
          default: s_d.rresp = `TPG_RESP_SLVERR;
        endcase
      end
      s_d.rdata = rv;
    end

    // beat taken by the transmitter
    if (s_q.tx_valid && tx_ready) begin
      s_d.tx_valid = 1'b0;
    end

    // line period timer in 10 ns units
    if (s_q.lbusy) begin
      s_d.acc = acc_nx;
      if (acc_nx >= {8'h00, s_q.period}) begin
        s_d.lbusy = 1'b0; // R7
      end
    end

    // frame sequencer
    unique case (s_q.st)
      TPG_ST_IDLE: begin
        if (s_q.ctrl_en) begin
          go_line = 1'b1;
          nl = 16'h0000;
        end
      end
      TPG_ST_SOF, TPG_ST_EOF: begin
        if (slot) begin
          s_d.tx_valid = 1'b1;
          s_d.tx_kind = (s_q.st == TPG_ST_SOF) ? `TPG_KIND_FS : `TPG_KIND_FE;
          s_d.tx_data = 8'h00;
          s_d.tx_last = 1'b1;
          s_d.st = TPG_ST_WAIT;
          // back porch counts from the line that holds frame start
          if ({1'b0, s_q.line} >= first_act && {1'b0, s_q.line} < end_act
              && s_q.line_len != 16'h0000) begin
            s_d.st = TPG_ST_DATA; // R9
          end
        end
      end
      TPG_ST_DATA: begin
        if (slot) begin
          s_d.tx_valid = 1'b1;
          s_d.tx_kind = `TPG_KIND_DATA;
          s_d.tx_data = src_byte; // R1 R12
          s_d.tx_last = (s_q.byte_cnt == s_q.line_len - 16'h0001);
          s_d.byte_cnt = s_q.byte_cnt + 16'h0001;
          // fixed block wraps at programmed size
          s_d.blk_idx = (s_q.blk_idx == s_q.cfg_blk) ? 4'h0 :
                        s_q.blk_idx + 4'h1; // R14
          // bar steps until the last, which fills the line
          if (s_q.bar_idx != bars_max(s_q.cfg_bars) &&
              s_q.bar_cnt == s_q.bar_w - 16'h0001) begin
            s_d.bar_idx = s_q.bar_idx + 3'h1; // R3 R4
            s_d.bar_cnt = 16'h0000;
          end else begin
            s_d.bar_cnt = s_q.bar_cnt + 16'h0001; // R2
          end
          if (s_q.byte_cnt == s_q.line_len - 16'h0001) begin
            s_d.st = TPG_ST_WAIT;
          end
        end
      end
      TPG_ST_WAIT: begin
        if (!s_q.lbusy || acc_nx >= {8'h00, s_q.period}) begin // R7
          if (s_q.line + 16'h0001 >= s_q.tot) begin
            s_d.frames = s_q.frames + 16'h0001;
            if (s_q.ctrl_en) begin
              go_line = 1'b1; // R20
              nl = 16'h0000;
            end else begin
              s_d.st = TPG_ST_IDLE;
            end
          end else begin
            go_line = 1'b1;
            nl = s_q.line + 16'h0001;
          end
        end
      end
    endcase

    // start of a line: restart timer and pattern counters
    if (go_line) begin
      s_d.line = nl;
      s_d.acc = 24'h00_0000;
      s_d.lbusy = 1'b1;
      s_d.byte_cnt = 16'h0000; // R20
      s_d.bar_idx = 3'h0;
      s_d.bar_cnt = 16'h0000;
      s_d.blk_idx = 4'h0;
      if (nl == 16'h0000) begin
        s_d.st = TPG_ST_SOF;
      end else if ({1'b0, nl} == eof_line) begin
        s_d.st = TPG_ST_EOF; // R8
      end else if ({1'b0, nl} >= first_act && {1'b0, nl} < end_act &&
                   s_q.line_len != 16'h0000) begin
        s_d.st = TPG_ST_DATA; // R6 R9
      end else begin
        s_d.st = TPG_ST_WAIT;
      end
    end
  end

  // single state register, synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.cfg_bars <= `TPG_RST_BARS;
      s_q.cfg_blk <= `TPG_RST_BLK;
      s_q.dt <= `TPG_RST_DT;
      s_q.line_len <= `TPG_RST_WORD;
      s_q.st <= TPG_ST_IDLE;
    end else begin
      s_q <= s_d; // R10
    end
  end

endmodule // tpg_generator
`default_nettype wire

// ---- shared/tpg_consts.svh ----
`ifndef TPG_CONSTS_SVH
`define TPG_CONSTS_SVH

// register byte offsets on the control bus
`define TPG_OFF_CTRL 8'h00
`define TPG_OFF_CFG 8'h04
`define TPG_OFF_CSI_ID 8'h08
`define TPG_OFF_LINE_LEN 8'h0c
`define TPG_OFF_BAR_W 8'h10
`define TPG_OFF_ACT 8'h14
`define TPG_OFF_TOT 8'h18
`define TPG_OFF_PERIOD 8'h1c
`define TPG_OFF_VBP 8'h20
`define TPG_OFF_VFP 8'h24
`define TPG_OFF_STATUS 8'h28
`define TPG_OFF_PAT0 8'h40

// field positions
`define TPG_CTRL_EN_BIT 0
`define TPG_CFG_BARS_LSB 0
`define TPG_CFG_FIXED_BIT 4
`define TPG_CFG_BLK_LSB 8
`define TPG_ID_DT_LSB 0
`define TPG_ID_VC_LSB 6

// reset values
`define TPG_RST_BARS 2'h3
`define TPG_RST_BLK 4'h2
`define TPG_RST_DT 6'h24
`define TPG_RST_WORD 16'h0000

// reference bar bytes, first to last
`define TPG_BAR0 8'haa
`define TPG_BAR1 8'h33
`define TPG_BAR2 8'hf0
`define TPG_BAR3 8'h7f
`define TPG_BAR4 8'h55
`define TPG_BAR5 8'hcc
`define TPG_BAR6 8'h0f
`define TPG_BAR7 8'h80

// stream beat kinds
`define TPG_KIND_DATA 2'h0
`define TPG_KIND_FS 2'h1
`define TPG_KIND_FE 2'h2

// bus responses
`define TPG_RESP_OKAY 2'h0
`define TPG_RESP_SLVERR 2'h2

// line timing: period counted in 10 ns units, clock of 20 ns
`define TPG_UNIT_NS 10
`define TPG_CLK_NS 20
`define TPG_STEP_UNITS (`TPG_CLK_NS / `TPG_UNIT_NS)

`endif

// ---- shared/tpg_pkg.sv ----
package tpg_pkg;

  typedef enum logic [2:0] {
    TPG_ST_IDLE,
    TPG_ST_SOF,
    TPG_ST_DATA,
    TPG_ST_WAIT,
    TPG_ST_EOF
  } tpg_state_t;

  typedef struct packed {
    // configuration
    logic ctrl_en;
    logic [1:0] cfg_bars;
    logic cfg_fixed;
    logic [3:0] cfg_blk;
    logic [5:0] dt;
    logic [1:0] vc;
    logic [15:0] line_len;
    logic [15:0] bar_w;
    logic [15:0] act;
    logic [15:0] tot;
    logic [15:0] period;
    logic [7:0] vbp;
    logic [7:0] vfp;
    logic [15:0][7:0] pat;
    // bus slave
    logic aw_have;
    logic [5:0] aw_idx;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    // frame engine
    tpg_state_t st;
    logic [15:0] line;
    logic [23:0] acc;
    logic lbusy;
    logic [15:0] byte_cnt;
    logic [2:0] bar_idx;
    logic [15:0] bar_cnt;
    logic [3:0] blk_idx;
    logic [15:0] frames;
    // stream output
    logic tx_valid;
    logic [1:0] tx_kind;
    logic [7:0] tx_data;
    logic tx_last;
  } tpg_s_t;

endpackage

// ---- design/tpg_byte_source.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tpg_consts.svh"

module tpg_byte_source (
  // selection
  input wire logic fixed_mode,
  input wire logic [2:0] bar_idx,
  input wire logic [3:0] blk_idx,
  // fixed pattern bytes
  input wire logic [15:0][7:0] pat,
  // chosen byte
  output logic [7:0] byte_out
);

  // reference bar colour by bar position
  function automatic logic [7:0] ref_byte(input logic [2:0] idx);
    unique case (idx)
      3'h0: ref_byte = `TPG_BAR0;
      3'h1: ref_byte = `TPG_BAR1;
      3'h2: ref_byte = `TPG_BAR2;
      3'h3: ref_byte = `TPG_BAR3;
      3'h4: ref_byte = `TPG_BAR4;
      3'h5: ref_byte = `TPG_BAR5;
      3'h6: ref_byte = `TPG_BAR6;
      3'h7: ref_byte = `TPG_BAR7;
    endcase
  endfunction

  // fixed block byte, inverted on odd bars, else bar colour
  always_comb begin
    if (fixed_mode) begin
      byte_out = pat[blk_idx] ^ {8{bar_idx[0]}}; // R12 R13 R15
    end else begin
      byte_out = ref_byte(bar_idx); // R1
    end
  end

endmodule // tpg_byte_source
`default_nettype wire

// ---- test/tpg_generator_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tpg_consts.svh"

module tpg_generator_monitor (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // stream
  input wire logic tx_ready,
  input wire logic tx_valid,
  input wire logic [1:0] tx_kind,
  input wire logic [7:0] tx_data,
  input wire logic tx_last
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // bus answers and their holding
  wr_resp_time_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid) else $error("write answer late");
  rd_resp_time_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  rd_data_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  wr_resp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  wr_busy_block_a: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  rd_busy_block_a: assert property (
    s_axi_arready ^ s_axi_rvalid) else $error("read ready wrong");
  // stream beats stay put until taken
  beat_hold_a: assert property (
    tx_valid && !tx_ready
    |=> tx_valid && $stable({tx_kind, tx_data, tx_last}))
    else $error("beat changed while stalled");
  short_pkt_a: assert property (
    tx_valid && tx_kind != `TPG_KIND_DATA
    |-> tx_last && tx_data == 8'h00 && tx_kind != 2'h3)
    else $error("bad short packet");
endmodule // tpg_generator_monitor

bind tpg_generator tpg_generator_monitor u_mon (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .tx_ready(tx_ready), .tx_valid(tx_valid),
  .tx_kind(tx_kind), .tx_data(tx_data), .tx_last(tx_last)
);
`default_nettype wire

// ---- test/tpg_tx_sink.sv ----
`timescale 1ns/1ps
`default_nettype none

module tpg_tx_sink (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pacing: low takes every beat, high one cycle in three
  input wire logic slow,
  // ready to the generator
  output logic tx_ready
);
  logic [1:0] ph_q;

  // phase counter for the slow pace
  always_ff @(posedge aclk) begin
    if (!aresetn) ph_q <= 2'h0;
    else ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
  end
  assign tx_ready = aresetn && (!slow || ph_q == 2'h0);
endmodule // tpg_tx_sink
`default_nettype wire

// ---- test/tpg_generator_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tpg_consts.svh"

module tpg_generator_tb_top;
  // clock, reset, bus
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0, slow = 1'h0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  // stream
  logic tx_ready, tx_valid, tx_last;
  logic [1:0] tx_kind, tx_vc;
  logic [7:0] tx_data;
  logic [5:0] tx_dt;
  logic [15:0] tx_wc;
  int err_total = 0, check_count = 0, cyc = 0;
  int len, bw, nb, blk, act, vbp, vfp, tot, lc;
  bit fx, want_d0;
  logic [7:0] pat [16];
  logic [10:0] beats [$];
  int fs_at [$], fe_at [$], d0_at [$];

  tpg_generator dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_ready(tx_ready),
    .tx_valid(tx_valid), .tx_kind(tx_kind), .tx_data(tx_data),
    .tx_last(tx_last), .tx_dt(tx_dt), .tx_vc(tx_vc), .tx_word_count(tx_wc));
  tpg_tx_sink u_sink (.aclk(aclk), .aresetn(aresetn), .slow(slow),
    .tx_ready(tx_ready));

  always #10 aclk = ~aclk;

  // beat log and watchdog
  always @(posedge aclk) begin
    cyc++;
    if (cyc > 60000) begin
      err_total++;
      end_sim();
    end
    if (tx_valid === 1'h1 && tx_ready === 1'h1) begin
      beats.push_back({tx_kind, tx_last, tx_data});
      if (tx_kind === `TPG_KIND_FS) fs_at.push_back(cyc);
      if (tx_kind === `TPG_KIND_FE) fe_at.push_back(cyc);
      if (tx_kind === `TPG_KIND_DATA && want_d0) d0_at.push_back(cyc);
      want_d0 = (tx_kind === `TPG_KIND_FS);
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ta, tw, tb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(negedge aclk);
      ta = awready;
      tw = wready;
      tb = bvalid;
      resp = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
    end while (!tb);
    bready <= 1'h0;
  endtask

  task automatic rdr(input logic [7:0] a);
    bit ta, tr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(negedge aclk);
      ta = arready;
      tr = rvalid;
      rd = rdata;
      resp = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'h0;
    end while (!tr);
    rready <= 1'h0;
  endtask

  // expected byte at line position k
  function automatic logic [7:0] expb(int k);
    logic [7:0] ref_b [8] = '{`TPG_BAR0, `TPG_BAR1, `TPG_BAR2, `TPG_BAR3,
      `TPG_BAR4, `TPG_BAR5, `TPG_BAR6, `TPG_BAR7};
    int b;
    b = (k / bw < nb - 1) ? k / bw : nb - 1;
    return fx ? pat[k % blk] ^ {8{b[0]}} : ref_b[b];
  endfunction

  function automatic logic [31:0] near(int x, int lo);
    return 32'(x >= lo - 3 && x <= lo + 3);
  endfunction

  // program geometry, run nf frames, check every beat
  task automatic frame(input int nf, input logic [31:0] cfg);
    int base;
    wr(`TPG_OFF_LINE_LEN, 32'(len));
    wr(`TPG_OFF_BAR_W, 32'(bw));
    wr(`TPG_OFF_ACT, 32'(act));
    wr(`TPG_OFF_TOT, 32'(tot));
    wr(`TPG_OFF_PERIOD, 32'(2 * lc));
    wr(`TPG_OFF_VBP, 32'(vbp));
    wr(`TPG_OFF_VFP, 32'(vfp));
    wr(`TPG_OFF_CFG, cfg);
    beats.delete();
    fs_at.delete();
    fe_at.delete();
    d0_at.delete();
    wr(`TPG_OFF_CTRL, 32'h1);
    while (fs_at.size() < nf) @(posedge aclk);
    wr(`TPG_OFF_CTRL, 32'h0);
    repeat (2 * tot * lc) @(posedge aclk);
    check(32'(beats.size()), 32'(nf * (2 + act * len)));
    check(32'(tx_wc), 32'(len));
    for (int f = 0; f < nf; f++) begin
      check(near(d0_at[f] - fs_at[f], vbp * lc + 1), 32'h1);
      check(near(fe_at[f] - fs_at[f], (vbp + act + vfp) * lc), 32'h1);
      if (f > 0) check(near(fs_at[f] - fs_at[f - 1], tot * lc), 32'h1);
      base = f * (2 + act * len);
      check(32'(beats[base]), {21'h0, `TPG_KIND_FS, 9'h100});
      for (int i = 0; i < act * len; i++) begin
        check(32'(beats[base + 1 + i]), {21'h0, `TPG_KIND_DATA,
          1'(i % len == len - 1), expb(i % len)});
      end
      base = base + 1 + act * len;
      check(32'(beats[base]), {21'h0, `TPG_KIND_FE, 9'h100});
    end
  endtask

  // reset values, unmapped place, pattern bytes
  task automatic regs_test();
    rdr(`TPG_OFF_CFG);
    check(rd, 32'h0000_0203);
    check(32'(resp), 32'(`TPG_RESP_OKAY));
    rdr(`TPG_OFF_CSI_ID);
    check(rd, 32'h0000_0024);
    rdr(8'h30);
    check(rd, 32'h0);
    check(32'(resp), 32'(`TPG_RESP_SLVERR));
    wr(8'h30, 32'h1);
    check(32'(resp), 32'(`TPG_RESP_SLVERR));
    for (int i = 0; i < 16; i++) begin
      wr(`TPG_OFF_PAT0 + 8'(4 * i), {24'hffffff, pat[i]});
    end
    check(32'(resp), 32'(`TPG_RESP_OKAY));
    rdr(`TPG_OFF_PAT0 + 8'h3c);
    check(rd, {24'h0, pat[15]});
  endtask

  initial begin
    for (int i = 0; i < 16; i++) pat[i] = 8'(i * 37 + 5);
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    regs_test();
    // eight bars, stretched last bar, slow sink, two frames
    len = 26; bw = 3; nb = 8; fx = 1'h0; blk = 3;
    act = 2; vbp = 1; vfp = 1; tot = 5; lc = 100;
    slow <= 1'h1;
    wr(`TPG_OFF_CSI_ID, 32'h0000_00ab);
    frame(2, 32'h0000_0203);
    check(32'({tx_vc, tx_dt}), 32'h0000_00ab);
    slow <= 1'h0;
    // one, two and four bars
    len = 12; act = 1; vbp = 0; vfp = 0; tot = 2; lc = 20;
    for (int c = 0; c < 3; c++) begin
      nb = 1 << c;
      frame(1, 32'(c));
    end
    // fixed pattern, five and sixteen byte blocks
    fx = 1'h1; act = 2; vfp = 1; tot = 4; lc = 30;
    blk = 5; nb = 2; bw = 5; len = 13;
    frame(1, 32'h0000_0411);
    blk = 16; nb = 4; bw = 4; len = 20;
    frame(1, 32'h0000_0f12);
    end_sim();
  end
endmodule // tpg_generator_tb_top
`default_nettype wire
